//--- bench/pbo_bus_agent.sv
// Far-side model: arbiter and target for the device's master cycles.
// Assumes its inputs are on clk_i; trdy released means pulled high.
`timescale 1ns/1ps
module pbo_bus_agent (
  input  wire logic clk_i,
  input  wire logic slow_i,   // Insert three wait states
  input  wire logic req_n_i,  // Request from the device
  input  wire logic irdy_n_i, // Device initiator ready
  output logic      gnt_n_o,  // Grant to the device
  output logic      trdy_n_o  // Target ready back
);
  logic [2:0] wait_ff = 3'h0; // Waits served this phase
  initial gnt_n_o = 1'b1;
  // Grant follows request one cycle late
  always @(posedge clk_i) begin
    gnt_n_o <= req_n_i;
    wait_ff <= irdy_n_i ? 3'h0 : wait_ff + 3'h1;
  end
  // Ready at once, or late when slow
  assign trdy_n_o = irdy_n_i | (slow_i & (wait_ff < 3'h3));
endmodule : pbo_bus_agent

//--- bench/pbo_props.sv
// Port assertions for the build-option glue block.
// Assumes it is bound onto pbo_top; one clock, sync active-high reset.
`timescale 1ns/1ps
module pbo_props
  import pbo_pkg::*;
#(
  parameter int unsigned BUS_WIDTH                   = 32,
  parameter int unsigned bus_speed_option            = 33,
  parameter bit          capability_list_off         = 1'b0,
  parameter bit          internal_arbitration_option = 1'b0,
  parameter bit          bus_clock_source_option     = 1'b0,
  parameter int unsigned internal_select_bit_choice  = 0
) (
  input wire logic                   clk_i,
  input wire logic                   srst_i,
  input wire logic [BUS_WIDTH-1:0]   ad_i,
  input wire logic [BUS_WIDTH/8-1:0] cbe_i,
  input wire logic                   idsel_pin_i,
  input wire logic                   par_o,
  input wire logic                   cfg_select_o,
  input wire logic [7:0]             cfg_addr_i,
  input wire logic [31:0]            cfg_rdata_o,
  input wire logic                   frame_n_o,
  input wire logic                   irdy_n_o,
  input wire logic                   trdy_n_o,
  input wire logic                   stop_n_o,
  input wire logic                   be_ready_i,
  input wire logic                   frame_copy_out_n,
  input wire logic                   initiator_ready_copy_out_n,
  input wire logic                   bus_clk_o,
  input wire logic                   bus_clk_oe_o
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  par_ok_a: assert property (
    !$past(srst_i) |-> par_o == ^{$past(ad_i), $past(cbe_i)}) else $error("parity wrong");
  sel_pin_a: assert property (
    internal_select_bit_choice == 0 && !$past(srst_i) |-> cfg_select_o == $past(idsel_pin_i))
    else $error("select not from pin");
  fast_bit_a: assert property (
    cfg_addr_i == CFG_CMD_STAT |=> cfg_rdata_o[STAT_66_BIT] == (bus_speed_option == 66))
    else $error("66 MHz bit wrong");
  cap_ptr_a: assert property (
    cfg_addr_i == CFG_CAP_PTR |=>
      cfg_rdata_o[7:0] == (capability_list_off ? 8'h00 : CFG_INT_REG)) else $error("cap ptr wrong");
  copy_idle_a: assert property (
    !internal_arbitration_option |-> frame_copy_out_n && initiator_ready_copy_out_n)
    else $error("copies active");
  clk_src_a: assert property (
    bus_clk_oe_o == bus_clock_source_option && (bus_clock_source_option || !bus_clk_o))
    else $error("bus clock option wrong");
  irdy_gap_a: assert property (
    $fell(frame_n_o) |-> irdy_n_o [*2] ##1 !irdy_n_o) else $error("irdy spacing wrong");
  ready_src_a: assert property (
    !trdy_n_o |-> be_ready_i) else $error("trdy without backend data");
  cover property ($fell(frame_n_o));
  cover property (!trdy_n_o);
  cover property (!stop_n_o);
endmodule : pbo_props

bind pbo_top pbo_props #(.BUS_WIDTH(BUS_WIDTH), .bus_speed_option(bus_speed_option),
  .capability_list_off(capability_list_off),
  .internal_arbitration_option(internal_arbitration_option),
  .bus_clock_source_option(bus_clock_source_option),
  .internal_select_bit_choice(internal_select_bit_choice)) u_props (.clk_i, .srst_i, .ad_i,
  .cbe_i, .idsel_pin_i, .par_o, .cfg_select_o, .cfg_addr_i, .cfg_rdata_o, .frame_n_o,
  .irdy_n_o, .trdy_n_o, .stop_n_o, .be_ready_i, .frame_copy_out_n,
  .initiator_ready_copy_out_n, .bus_clk_o, .bus_clk_oe_o);

//--- bench/tb.sv
// Self-checking bench for the build-option glue block.
// Assumes pbo_props is bound and pbo_bus_agent answers master cycles.
`timescale 1ns/1ps
module tb;
  import pbo_pkg::*;
  typedef struct packed {logic [1:0] s; logic [31:0] m; logic [31:0] e;} pbo_note_t;
  logic        clk_i = 1'b0, srst_i = 1'b1, idsel_pin_i = 1'b0, cfg_wr_i = 1'b0;
  logic [31:0] ad_i = 32'h0, cfg_wdata_i = 32'h0, cfg_rdata_o;
  logic [3:0]  cbe_i = 4'h0;
  logic        tb_frame_n = 1'b1, tb_irdy_n = 1'b1, irq_n = 1'b1, slow = 1'b0;
  logic        tgt_start_i = 1'b0, be_ready_i = 1'b0, mst_go_i = 1'b0, mst_stall_i = 1'b0;
  logic [15:0] tgt_addr_i = 16'h0, ql = 16'h0, be_addr_o;
  logic [7:0]  cfg_addr_i = 8'h0;
  logic        par_o, trdy_n_o, stop_n_o, frame_n_o, irdy_n_o, cfg_select_o;
  logic        req_pad_n_o, inta_oe_o, gnt_n, trdy_n, be_strobe_o;
  wire logic   frm_n = tb_frame_n & (frame_n_o !== 1'b0); // Wired bus frame
  wire logic   ird_n = tb_irdy_n & (irdy_n_o !== 1'b0);   // Wired bus irdy
  pbo_note_t   exp_q[$];
  int          num_errors = 0, checks_done = 0;
  always #10 clk_i = ~clk_i;
  pbo_top #(.bus_speed_option(66), .INT_MODE(0)) dut (.clk_i, .srst_i, .ad_i, .cbe_i,
    .frame_n_i(frm_n), .irdy_n_i(ird_n), .trdy_n_i(trdy_n), .idsel_pin_i, .par_o, .trdy_n_o,
    .stop_n_o, .frame_n_o, .irdy_n_o, .tgt_start_i, .tgt_read_i(1'b0), .tgt_addr_i,
    .be_ready_i, .be_addr_o, .be_strobe_o, .cfg_select_o, .mst_go_i, .mst_stall_i,
    .mst_last_i(1'b1), .gnt_pad_n_i(gnt_n), .gnt_int_n_i(1'b1), .req_pad_n_o,
    .req_pad_oe_o(), .req_int_n_o(), .frame_copy_out_n(), .initiator_ready_copy_out_n(),
    .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .queue_level_i(ql), .cfg_rdata_o,
    .external_irq_in_n(irq_n), .inta_n_o(), .inta_oe_o, .bus_clk_o(), .bus_clk_oe_o());
  pbo_bus_agent u_agent (.clk_i, .slow_i(slow), .req_n_i(req_pad_n_o !== 1'b0),
    .irdy_n_i(irdy_n_o !== 1'b0), .gnt_n_o(gnt_n), .trdy_n_o(trdy_n));
  // ****************
  // Observation and scoreboard
  // ****************
  function automatic logic [31:0] obs(logic [1:0] s);
    case (s)
      2'h0: return cfg_rdata_o;
      2'h1: return {24'h0, be_strobe_o, inta_oe_o, cfg_select_o, par_o, stop_n_o, trdy_n_o,
                    irdy_n_o,
                    frame_n_o};
      default: return {16'h0, be_addr_o};
    endcase
  endfunction : obs
  // Compare every note due at this edge
  always @(posedge clk_i) begin : mon
    pbo_note_t n;
    while (exp_q.size() > 0) begin
      n = exp_q.pop_front();
      checks_done++;
      if ((obs(n.s) & n.m) !== n.e) begin
        num_errors++;
        $display("Error at %0t: view %0d got %h want %h", $time, n.s, obs(n.s) & n.m, n.e);
      end
    end
  end
  task automatic chk(logic [1:0] s, logic [31:0] m, logic [31:0] e);
    exp_q.push_back('{s, m, e});
  endtask : chk
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait for a view to match
  task automatic wait_for(logic [1:0] s, logic [31:0] m, logic [31:0] e, int lim);
    int k = 0;
    while ((obs(s) & m) !== e && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= lim) begin
      num_errors++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_for
  task automatic cfg(logic [7:0] a, logic w, logic [31:0] d);
    cfg_addr_i = a;
    cfg_wr_i = w;
    cfg_wdata_i = d;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
  endtask : cfg
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    cfg_addr_i = a;
    @(negedge clk_i);
    chk(2'h0, m, e);
    @(negedge clk_i);
  endtask : rd
  // Start a target transfer as the bus initiator
  task automatic tgt(logic [15:0] a, logic rdy);
    tgt_addr_i = a;
    tgt_start_i = 1'b1;
    tb_frame_n = 1'b0;
    tb_irdy_n = 1'b0;
    be_ready_i = rdy;
    @(negedge clk_i);
    tgt_start_i = 1'b0;
  endtask : tgt
  task automatic tgt_end();
    tb_frame_n = 1'b1;
    @(negedge clk_i);
    tb_irdy_n = 1'b1;
    // Idle bus for a cycle before the next start may lower irdy again
    @(negedge clk_i);
    wait_for(2'h1, 32'hc, 32'hc, 20);
  endtask : tgt_end
  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] d;
    void'($urandom(57));
    ql = 16'($urandom);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    chk(2'h1, 32'hcf, 32'h0f);
    @(negedge clk_i);
    $display("Test reset done");
    repeat (8) begin
      chk(2'h1, 32'h30, {26'h0, idsel_pin_i, ^{ad_i, cbe_i}, 4'h0});
      ad_i = $urandom;
      cbe_i = 4'($urandom);
      idsel_pin_i = 1'($urandom);
      @(negedge clk_i);
    end
    $display("Test parity done");
    rd(CFG_CMD_STAT, 32'h0030_0000, 32'h0030_0000);
    rd(CFG_CAP_PTR, 32'hff, {24'h0, CFG_INT_REG});
    rd(CFG_QUEUE_STAT, 32'hffff, 32'h0);
    for (int a = 8'h50; a <= 8'h5c; a += 4) begin
      d = $urandom;
      cfg(8'(a), 1'b1, d);
      rd(8'(a), 32'hffff_ffff, d);
    end
    $display("Test config done");
    cfg(CFG_INT_REG, 1'b1, 32'h1);
    irq_n = 1'b0;
    wait_for(2'h1, 32'h40, 32'h40, 8);
    rd(CFG_INT_REG, 32'h2, 32'h2);
    rd(CFG_CMD_STAT, 32'h0008_0000, 32'h0008_0000);
    cfg(CFG_CMD_STAT, 1'b1, 32'h400);
    wait_for(2'h1, 32'h40, 32'h0, 4);
    irq_n = 1'b1;
    cfg(CFG_CMD_STAT, 1'b1, 32'h0);
    $display("Test interrupt done");
    tgt(16'h0100, 1'b1);
    for (int i = 0; i < 3; i++) begin
      chk(2'h2, 32'hffff, 32'h100 + 32'(4 * i));
      chk(2'h1, 32'h8c, 32'h88);
      if (i == 2) tb_frame_n = 1'b1;
      @(negedge clk_i);
    end
    tgt_end();
    tgt(16'h0200, 1'b0);
    repeat (8) begin
      chk(2'h1, 32'h8c, 32'hc);
      @(negedge clk_i);
    end
    wait_for(2'h1, 32'h8, 32'h0, 12);
    tgt_end();
    tgt(16'hfffc, 1'b1);
    chk(2'h1, 32'h8, 32'h0);
    @(negedge clk_i);
    tgt_end();
    $display("Test target done");
    for (int s = 0; s < 2; s++) begin
      slow = 1'(s);
      mst_stall_i = 1'b1; // Backend fetch ends under stall
      mst_go_i = 1'b1;
      @(negedge clk_i);
      mst_go_i = 1'b0;
      repeat (3) begin
        chk(2'h1, 32'h3, 32'h3);
        @(negedge clk_i);
      end
      mst_stall_i = 1'b0;
      wait_for(2'h1, 32'h1, 32'h0, 8);
      chk(2'h1, 32'h2, 32'h2);
      @(negedge clk_i);
      chk(2'h1, 32'h2, 32'h2);
      @(negedge clk_i);
      chk(2'h1, 32'h2, 32'h0);
      @(negedge clk_i);
      wait_for(2'h1, 32'h3, 32'h3, 12);
    end
    $display("Test master done");
    @(negedge clk_i);
    report_and_stop();
  end
endmodule : tb

//--- logic/pbo_pkg.sv
// Constants and types for the PCI build-option glue block.
// Assumes one PCI clock domain and a synchronous active-high reset.
//
// Behaviour
// - 66 MHz build sets capable status bit
// - Bus width selects 32 or 64 bits
// - Master and target functions included by option
// - Slow read inserts wait state per read data phase
// - Watchdog stops cycle on backend latency overrun
// - BAR end disconnects, or wraps when disabled
// - Overflow check may disconnect bursts early
// - Capability removal zeroes pointer, keeps registers
// - Interrupt modes: register, off, passthrough
// - Modes 0 and 2 give disable/status bits
// - Queue status register present only by option
// - Backend address width 8 to 32 bits
// - Internal arbiter: no pads, frame/irdy copies
// - Select from AD bit n, else pin
// - Stall timing delays frame, irdy follows it by one clock
// - Device generates bus clock by option
// - Storage in flip-flops, same behaviour
package pbo_pkg;
  // ************************************************************
  // Option defaults
  // ************************************************************
  localparam int unsigned BUS_WIDTH_DEF    = 32;  // 32 or 64
  localparam int unsigned BUS_SPEED_DEF    = 33;  // 33 or 66
  localparam int unsigned BUS_SPEED_FAST   = 66;  // Speed that sets capable bit
  localparam int unsigned ADDR_BITS_DEF    = 16;  // Backend address width
  localparam int unsigned ADDR_BITS_MIN    = 8;   // Least legal backend width
  // ************************************************************
  // Configuration space offsets and fields
  // ************************************************************
  localparam logic [7:0] CFG_CMD_STAT    = 8'h04; // Command and status dword
  localparam logic [7:0] CFG_CAP_PTR     = 8'h34; // Capability pointer
  localparam logic [7:0] CFG_INT_REG     = 8'h48; // Interrupt register
  localparam logic [7:0] CFG_QUEUE_STAT  = 8'h4c; // Queue status register
  localparam logic [7:0] CFG_DMA_BASE    = 8'h50; // First DMA control register
  localparam logic [7:0] CFG_DMA_LAST    = 8'h5c; // Last DMA control register
  localparam int unsigned CMD_INT_DIS_BIT  = 10;  // Interrupt disable in command
  localparam int unsigned STAT_INT_BIT     = 19;  // Interrupt status
  localparam int unsigned STAT_CAP_BIT     = 20;  // Capability list present
  localparam int unsigned STAT_66_BIT      = 21;  // 66 MHz capable
  localparam int unsigned INT_EN_BIT       = 0;   // Enable in interrupt register
  localparam int unsigned INT_PEND_BIT     = 1;   // Pending in interrupt register
  // ************************************************************
  // Timing counts
  // ************************************************************
  localparam int unsigned WDOG_FIRST_CLKS  = 16;  // Initial data latency limit
  localparam int unsigned WDOG_NEXT_CLKS   = 8;   // Subsequent data latency limit
  localparam int unsigned BAR_LOOKAHEAD    = 2;   // Words before top that stop early
  localparam logic [4:0]  WDOG_FIRST = 5'(WDOG_FIRST_CLKS);
  localparam logic [4:0]  WDOG_NEXT  = 5'(WDOG_NEXT_CLKS);
  // ************************************************************
  // State machines
  // ************************************************************
  typedef enum logic [3:0] {
    PBO_T_IDLE = 4'h1, PBO_T_WAIT = 4'h2, PBO_T_DATA = 4'h4, PBO_T_STOP = 4'h8
  } pbo_tstate_t;
  typedef enum logic [5:0] {
    PBO_M_IDLE = 6'h01, PBO_M_REQ = 6'h02, PBO_M_HOLD = 6'h04,
    PBO_M_ADDR = 6'h08, PBO_M_GAP = 6'h10, PBO_M_DATA = 6'h20
  } pbo_mstate_t;
endpackage : pbo_pkg

//--- logic/pbo_top.sv
// PCI build-option glue: target and master sequencing, config view,
// interrupt, arbiter, select and clock options.
// Assumes every bus input is already on clk_i; only the external
// interrupt arrives asynchronously.
`timescale 1ns/1ps
module pbo_top
  import pbo_pkg::*;
#(  // Options fixed at elaboration
  parameter int unsigned BUS_WIDTH          = BUS_WIDTH_DEF,
  parameter int unsigned bus_speed_option   = BUS_SPEED_DEF,
  parameter bit          MASTER_ON          = 1'b1,
  parameter bit          TARGET_ON          = 1'b1,
  parameter bit          SLOW_READ_ON       = 1'b0,
  parameter bit          transfer_timeout_off      = 1'b0,
  parameter bit          window_overflow_check_off = 1'b0,
  parameter bit          capability_list_off       = 1'b0,
  parameter int unsigned INT_MODE           = 0,
  parameter bit          queue_status_reg_on       = 1'b0,
  parameter int unsigned backend_addr_bits  = ADDR_BITS_DEF,
  parameter bit          bus_clock_source_option   = 1'b0,
  parameter bit          internal_arbitration_option = 1'b0,
  parameter int unsigned internal_select_bit_choice  = 0,
  parameter bit          STALL_TIMING       = 1'b0,
  parameter int unsigned BE_W               = BUS_WIDTH / 8
) (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  // Bus side, already on clk_i
  input  wire logic [BUS_WIDTH-1:0]          ad_i,
  input  wire logic [BE_W-1:0]               cbe_i,
  input  wire logic                          frame_n_i,
  input  wire logic                          irdy_n_i,
  input  wire logic                          trdy_n_i,
  input  wire logic                          idsel_pin_i,
  output logic                               par_o,
  output logic                               trdy_n_o,
  output logic                               stop_n_o,
  output logic                               frame_n_o,
  output logic                               irdy_n_o,
  // Target request from address decode
  input  wire logic                          tgt_start_i,
  input  wire logic                          tgt_read_i,
  input  wire logic [backend_addr_bits-1:0]  tgt_addr_i,
  input  wire logic                          be_ready_i,
  output logic [backend_addr_bits-1:0]       be_addr_o,
  output logic                               be_strobe_o,
  output logic                               cfg_select_o,
  // Master request from DMA engine
  input  wire logic                          mst_go_i,
  input  wire logic                          mst_stall_i,
  input  wire logic                          mst_last_i,
  // Arbitration pads and internal paths
  input  wire logic                          gnt_pad_n_i,
  input  wire logic                          gnt_int_n_i,
  output logic                               req_pad_n_o,
  output logic                               req_pad_oe_o,
  output logic                               req_int_n_o,
  output logic                               frame_copy_out_n,
  output logic                               initiator_ready_copy_out_n,
  // Configuration access
  input  wire logic                          cfg_wr_i,
  input  wire logic [7:0]                    cfg_addr_i,
  input  wire logic [31:0]                   cfg_wdata_i,
  input  wire logic [15:0]                   queue_level_i,
  output logic [31:0]                        cfg_rdata_o,
  // Interrupt, open-drain
  input  wire logic                          external_irq_in_n,
  output logic                               inta_n_o,
  output logic                               inta_oe_o,
  // Generated bus clock
  output logic                               bus_clk_o,
  output logic                               bus_clk_oe_o
);
  localparam logic [backend_addr_bits-1:0] WSTEP = backend_addr_bits'(BE_W);
  localparam logic [backend_addr_bits-1:0] TOP_WORD = '1 - (WSTEP - 1'b1);
  localparam logic [backend_addr_bits-1:0] EARLY =
    TOP_WORD - backend_addr_bits'(BAR_LOOKAHEAD) * WSTEP;

  // ************************************************************
  // Interrupt input synchroniser
  // ************************************************************
  logic irq_s1_ff, irq_s2_ff;         // Two-stage, active high after flip
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
    end else begin
      irq_s1_ff <= ~external_irq_in_n;
      irq_s2_ff <= irq_s1_ff;
    end
  end

  // ************************************************************
  // Target sequencer
  // ************************************************************
  pbo_tstate_t                  t_ff, nxt_t;       // Target state
  logic [backend_addr_bits-1:0] addr_ff, nxt_addr; // Window address
  logic [4:0]                   wdog_ff, nxt_wdog; // Latency count
  logic                         first_ff, nxt_first; // First data phase
  logic                         rd_ff, nxt_rd;     // Read transfer
  logic                         xfer;              // Data phase completes
  logic                         at_top, near_top, wd_hit;

  always_comb begin
    xfer     = (t_ff == PBO_T_DATA) && be_ready_i && !irdy_n_i;
    at_top   = (addr_ff >= TOP_WORD);
    near_top = (addr_ff >= EARLY);
    wd_hit   = !transfer_timeout_off &&
               (wdog_ff >= (first_ff ? WDOG_FIRST : WDOG_NEXT));
  end

  // Next target state and counters
  always_comb begin
    nxt_t     = t_ff;
    nxt_addr  = addr_ff;
    nxt_wdog  = wdog_ff;
    nxt_first = first_ff;
    nxt_rd    = rd_ff;
    unique case (t_ff)
      PBO_T_IDLE: begin
        if (TARGET_ON && tgt_start_i) begin
          nxt_addr  = tgt_addr_i;
          nxt_rd    = tgt_read_i;
          nxt_first = 1'b1;
          nxt_wdog  = '0;
          // Read gets one wait state, no holding store needed
          nxt_t = (SLOW_READ_ON && tgt_read_i) ? PBO_T_WAIT : PBO_T_DATA;
        end
      end
      PBO_T_WAIT: begin
        nxt_t    = PBO_T_DATA;
        nxt_wdog = wdog_ff + 5'h01;
      end
      PBO_T_DATA: begin
        if (frame_n_i && xfer) begin
          nxt_t = PBO_T_IDLE;                        // Last phase done
        end else if (xfer) begin
          nxt_first = 1'b0;
          nxt_wdog  = '0;
          nxt_addr  = addr_ff + WSTEP;               // Wraps when check off
          if (!window_overflow_check_off && (at_top || near_top)) begin
            nxt_t = PBO_T_STOP;
          end else if (SLOW_READ_ON && rd_ff) begin
            nxt_t = PBO_T_WAIT;
          end
        end else if (wd_hit) begin
          nxt_t = PBO_T_STOP;                        // Backend too slow
        end else begin
          nxt_wdog = wdog_ff + 5'h01;
        end
      end
      PBO_T_STOP: begin
        if (frame_n_i) begin
          nxt_t = PBO_T_IDLE;                        // Initiator released
        end
      end
      default: nxt_t = PBO_T_IDLE;
    endcase
    if (!frame_n_i && t_ff == PBO_T_IDLE) begin
      nxt_first = nxt_first;
    end
  end

  // Target registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      t_ff     <= PBO_T_IDLE;
      addr_ff  <= '0;
      wdog_ff  <= '0;
      first_ff <= 1'b0;
      rd_ff    <= 1'b0;
    end else begin
      t_ff     <= nxt_t;
      addr_ff  <= nxt_addr;
      wdog_ff  <= nxt_wdog;
      first_ff <= nxt_first;
      rd_ff    <= nxt_rd;
    end
  end

  // Target handshake outputs
  always_comb begin
    trdy_n_o    = !((t_ff == PBO_T_DATA) && be_ready_i);
    // Disconnect with data from BAR_LOOKAHEAD words below the top word onward
    stop_n_o    = !((t_ff == PBO_T_STOP) || ((t_ff == PBO_T_DATA) && wd_hit) ||
                    ((t_ff == PBO_T_DATA) && !window_overflow_check_off &&
                     (at_top || near_top)));
    be_strobe_o = xfer;
    be_addr_o   = addr_ff;
  end

  // ************************************************************
  // Master sequencer
  // ************************************************************
  pbo_mstate_t m_ff, nxt_m;           // Master state
  logic        gnt_n;                 // Grant from chosen source

  always_comb begin
    gnt_n = internal_arbitration_option ? gnt_int_n_i : gnt_pad_n_i;
  end

  // Next master state
  always_comb begin
    nxt_m = m_ff;
    unique case (m_ff)
      PBO_M_IDLE: if (MASTER_ON && mst_go_i) nxt_m = PBO_M_REQ;
      PBO_M_REQ: begin
        // Held while stalled; option delays frame and shortens its gap to irdy
        if (!gnt_n && frame_n_i && irdy_n_i && !mst_stall_i) begin
          nxt_m = STALL_TIMING ? PBO_M_HOLD : PBO_M_ADDR;
        end
      end
      PBO_M_HOLD: nxt_m = PBO_M_ADDR;                 // Extra clock
      // Mode 1 relies on the fetch ending under stall
      PBO_M_ADDR: nxt_m = STALL_TIMING ? PBO_M_DATA : PBO_M_GAP;
      PBO_M_GAP:  nxt_m = PBO_M_DATA;
      PBO_M_DATA: if (!trdy_n_i && mst_last_i) nxt_m = PBO_M_IDLE;
      default:    nxt_m = PBO_M_IDLE;
    endcase
  end

  // Master register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      m_ff <= PBO_M_IDLE;
    end else begin
      m_ff <= nxt_m;
    end
  end

  // Master drive and arbiter wiring
  always_comb begin
    frame_n_o = !((m_ff == PBO_M_ADDR) || (m_ff == PBO_M_GAP) ||
                  ((m_ff == PBO_M_DATA) && !mst_last_i));
    irdy_n_o  = !(m_ff == PBO_M_DATA);
    req_int_n_o  = internal_arbitration_option ? !(m_ff == PBO_M_REQ) : 1'b1;
    req_pad_n_o  = internal_arbitration_option ? 1'b1 : !(m_ff == PBO_M_REQ);
    req_pad_oe_o = !internal_arbitration_option;       // No pad
    frame_copy_out_n           = internal_arbitration_option ? frame_n_o : 1'b1;
    initiator_ready_copy_out_n = internal_arbitration_option ? irdy_n_o : 1'b1;
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic        int_dis_ff, nxt_int_dis;   // Command interrupt disable
  logic        int_en_ff, nxt_int_en;     // Interrupt register enable
  logic [31:0] dma_ff [4];                // DMA control words, flip-flops
  logic [31:0] nxt_dma [4];
  logic [31:0] rdata_ff, nxt_rdata;
  logic        par_ff, nxt_par;
  logic        int_src;                   // Interrupt condition
  logic        inta_ff, nxt_inta;
  logic        clk_div_ff, nxt_clk_div;   // Generated clock
  logic        sel_ff, nxt_sel;

  // Interrupt source per mode
  always_comb begin
    unique case (INT_MODE)
      0:       int_src = irq_s2_ff && int_en_ff;
      2:       int_src = irq_s2_ff;                   // Passthrough
      default: int_src = 1'b0;                        // Disabled
    endcase
    nxt_inta = int_src && !((INT_MODE != 1) && int_dis_ff);
  end

  // Config writes, read mux, parity, select and clock
  always_comb begin
    nxt_int_dis = int_dis_ff;
    nxt_int_en  = int_en_ff;
    nxt_dma     = dma_ff;
    if (cfg_wr_i) begin
      if (cfg_addr_i == CFG_CMD_STAT && INT_MODE != 1) begin
        nxt_int_dis = cfg_wdata_i[CMD_INT_DIS_BIT];
      end
      if (cfg_addr_i == CFG_INT_REG && INT_MODE == 0) begin
        nxt_int_en = cfg_wdata_i[INT_EN_BIT];
      end
      if (cfg_addr_i >= CFG_DMA_BASE && cfg_addr_i <= CFG_DMA_LAST) begin
        nxt_dma[cfg_addr_i[3:2]] = cfg_wdata_i;
      end
    end
    nxt_rdata = '0;
    unique case (cfg_addr_i)
      CFG_CMD_STAT: begin
        nxt_rdata[CMD_INT_DIS_BIT] = (INT_MODE != 1) && int_dis_ff;
        nxt_rdata[STAT_INT_BIT]    = (INT_MODE != 1) && int_src;
        nxt_rdata[STAT_CAP_BIT]    = !capability_list_off;
        nxt_rdata[STAT_66_BIT]     = (bus_speed_option == BUS_SPEED_FAST);
      end
      CFG_CAP_PTR:  nxt_rdata[7:0] = capability_list_off ? 8'h00 : CFG_INT_REG;
      CFG_INT_REG: begin
        nxt_rdata[INT_EN_BIT]   = (INT_MODE == 0) && int_en_ff;
        nxt_rdata[INT_PEND_BIT] = (INT_MODE == 0) && irq_s2_ff;
      end
      CFG_QUEUE_STAT: nxt_rdata[15:0] = queue_status_reg_on ? queue_level_i : 16'h0000;
      default: begin
        if (cfg_addr_i >= CFG_DMA_BASE && cfg_addr_i <= CFG_DMA_LAST) begin
          nxt_rdata = dma_ff[cfg_addr_i[3:2]];
        end
      end
    endcase
    nxt_par     = ^{ad_i, cbe_i};                    // Width follows bus
    nxt_clk_div = bus_clock_source_option ? !clk_div_ff : 1'b0;
    nxt_sel     = (internal_select_bit_choice != 0) ?
                  ad_i[internal_select_bit_choice % BUS_WIDTH] : idsel_pin_i;
  end

  // Config and misc registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_dis_ff <= 1'b0;
      int_en_ff  <= 1'b0;
      dma_ff     <= '{default: 32'h0000_0000};
      rdata_ff   <= '0;
      par_ff     <= 1'b0;
      inta_ff    <= 1'b0;
      clk_div_ff <= 1'b0;
      sel_ff     <= 1'b0;
    end else begin
      int_dis_ff <= nxt_int_dis;
      int_en_ff  <= nxt_int_en;
      dma_ff     <= nxt_dma;
      rdata_ff   <= nxt_rdata;
      par_ff     <= nxt_par;
      inta_ff    <= nxt_inta;
      clk_div_ff <= nxt_clk_div;
      sel_ff     <= nxt_sel;
    end
  end

  // Registered outputs
  always_comb begin
    cfg_rdata_o  = rdata_ff;
    par_o        = par_ff;
    inta_n_o     = 1'b0;                 // Open drain pulls low only
    inta_oe_o    = inta_ff;
    bus_clk_o    = clk_div_ff;
    bus_clk_oe_o = bus_clock_source_option;
    cfg_select_o = sel_ff;
  end
endmodule : pbo_top
